// >>> core/pipeline_hold_interlock.sv
`timescale 1ns/1ns
module pipeline_hold_interlock #(
	parameter int PTR_COUNT = 3
) (
	// Clock, enable and reset.
	input wire logic aclk,
	input wire logic ce,
	input wire logic aresetn,
	// Urgent warning pin, asynchronous.
	input wire logic warn_pin,
	// AXI4-Lite register port.
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Fetch and cache status.
	input wire logic instr_needed,
	input wire logic instr_valid,
	input wire logic data_needed,
	input wire logic data_valid,
	input wire logic dcache_miss,
	input wire logic bus_busy,
	input wire logic nc_busy,
	input wire logic refill_active,
	input wire logic wbuf_full,
	input wire logic wbuf_empty,
	// Execute-stage requests.
	input wire pipe_hold_pkg::exec_req_type exec_req,
	input wire logic [7:0] src_a,
	input wire logic [7:0] src_b,
	input wire logic load_return,
	input wire logic serialize_req,
	input wire logic multiple_active,
	// Trap and interrupt return progress.
	input wire logic trap_taken,
	input wire logic iret_exec,
	input wire logic handler_in_exec,
	input wire logic iret_done,
	// Branches.
	input wire logic branch_taken,
	input wire logic [31:0] branch_target,
	// Delayed-effect register writes.
	input wire logic sp_write,
	input wire logic [31:0] sp_wdata,
	input wire logic [PTR_COUNT-1:0] ptr_write,
	input wire logic [7:0] ptr_wdata,
	input wire logic cache_if_write,
	input wire logic cache_data_access,
	// Pipeline control outputs.
	output logic hold,
	output logic [3:0] stage_advance,
	output logic wbuf_push,
	output logic nc_start,
	output logic [31:0] fetch_pc,
	output logic in_delay_slot,
	output logic irq_allow,
	output logic [31:0] sp_direct,
	output logic [31:0] sp_local,
	output logic [PTR_COUNT-1:0][7:0] ptr_effective,
	output logic [pipe_hold_pkg::PAGE_SIZE_WIDTH-1:0] tr_page_size,
	output logic cache_order_fault
);
	// ================================================================
	// Warning pin synchroniser and filter.
	logic [2:0] warn_sync;
	logic warn_level;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			warn_sync <= 3'h0;
			warn_level <= 1'b0;
		end else if (ce) begin
			warn_sync <= {warn_sync[1:0], warn_pin};
			if (warn_sync[1] == warn_sync[2]) begin
				warn_level <= warn_sync[2];
			end
		end
	end

	// ================================================================
	// Software registers.
	logic [1:0] ctrl;
	logic [pipe_hold_pkg::PAGE_SIZE_WIDTH-1:0] page_size_field;
	logic fault;
	logic [31:0] hold_count;
	logic state_freeze_bit;
	logic [7:0] aw_addr;
	logic aw_held;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic w_held;
	logic do_write;
	logic wr_mapped;
	logic rd_mapped;
	logic fault_clear;
	pipe_hold_pkg::stall_cause_type cause;
	logic next_hold;
	logic [31:0] read_value;

	assign state_freeze_bit = ctrl[pipe_hold_pkg::CTRL_FREEZE_BIT];
	assign do_write = aw_held && w_held && !bvalid;
	assign wr_mapped = aw_addr == pipe_hold_pkg::CTRL_OFFSET
		|| aw_addr == pipe_hold_pkg::CONFIG_OFFSET
		|| aw_addr == pipe_hold_pkg::FAULT_OFFSET;
	assign rd_mapped = araddr == pipe_hold_pkg::CTRL_OFFSET
		|| araddr == pipe_hold_pkg::CONFIG_OFFSET
		|| araddr == pipe_hold_pkg::STATUS_OFFSET
		|| araddr == pipe_hold_pkg::FAULT_OFFSET
		|| araddr == pipe_hold_pkg::HOLD_COUNT_OFFSET;
	assign fault_clear = do_write && aw_addr == pipe_hold_pkg::FAULT_OFFSET && w_strb[0]
		&& w_data[pipe_hold_pkg::FAULT_CACHE_ORDER_BIT];

	// Write address and data are taken in either order and held.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= pipe_hold_pkg::RESP_OKAY;
		end else if (ce) begin
			if (awvalid && awready) begin
				aw_held <= 1'b1;
				aw_addr <= awaddr;
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				w_held <= 1'b1;
				w_data <= wdata;
				w_strb <= wstrb;
				wready <= 1'b0;
			end
			if (do_write) begin
				bvalid <= 1'b1;
				bresp <= wr_mapped ? pipe_hold_pkg::RESP_OKAY : pipe_hold_pkg::RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
				aw_held <= 1'b0;
				w_held <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= pipe_hold_pkg::CTRL_RESET;
			page_size_field <= pipe_hold_pkg::PAGE_SIZE_RESET;
		end else if (ce && do_write && w_strb[0]) begin
			if (aw_addr == pipe_hold_pkg::CTRL_OFFSET) begin
				ctrl <= w_data[1:0];
			end
			if (aw_addr == pipe_hold_pkg::CONFIG_OFFSET) begin
				page_size_field <= w_data[pipe_hold_pkg::PAGE_SIZE_WIDTH-1:0];
			end
		end
	end

	always_comb begin
		read_value = 32'h0000_0000;
		case (araddr)
			pipe_hold_pkg::CTRL_OFFSET: read_value[1:0] = ctrl;
			pipe_hold_pkg::CONFIG_OFFSET:
				read_value[pipe_hold_pkg::PAGE_SIZE_WIDTH-1:0] = page_size_field;
			pipe_hold_pkg::STATUS_OFFSET: begin
				read_value[pipe_hold_pkg::STATUS_HOLD_BIT] = hold;
				read_value[pipe_hold_pkg::STATUS_IRQ_OK_BIT] = irq_allow;
				read_value[pipe_hold_pkg::STATUS_CAUSE_LSB +: 12] = cause;
			end
			pipe_hold_pkg::FAULT_OFFSET: read_value[pipe_hold_pkg::FAULT_CACHE_ORDER_BIT] = fault;
			pipe_hold_pkg::HOLD_COUNT_OFFSET: read_value = hold_count;
			default: read_value = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= pipe_hold_pkg::RESP_OKAY;
		end else if (ce) begin
			if (arvalid && arready) begin
				arready <= 1'b0;
				rvalid <= 1'b1;
				rdata <= read_value;
				rresp <= rd_mapped ? pipe_hold_pkg::RESP_OKAY : pipe_hold_pkg::RESP_SLVERR;
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

	// ================================================================
	// Trap, interrupt return and load scoreboard state.
	logic trap_pending;
	logic iret_pending;
	logic load_pending;
	logic [7:0] load_reg;

	// A new trap or return in the same cycle as its end keeps the wait.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trap_pending <= 1'b0;
			iret_pending <= 1'b0;
		end else if (ce) begin
			trap_pending <= trap_taken || (trap_pending && !handler_in_exec);
			iret_pending <= iret_exec || (iret_pending && !iret_done);
		end
	end

	// One outstanding load destination; a returning load frees it unless
	// a new load issues in the same cycle.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			load_pending <= 1'b0;
			load_reg <= 8'h00;
		end else if (ce) begin
			if (exec_req.load && !next_hold) begin
				load_pending <= 1'b1;
				load_reg <= exec_req.load_dest;
			end else if (load_return) begin
				load_pending <= 1'b0;
			end
		end
	end

	// ================================================================
	// Hold formation.
	always_comb begin
		cause.instr_miss = instr_needed && !instr_valid;
		cause.data_miss = data_needed && !data_valid;
		cause.nc_conflict = exec_req.noncacheable && nc_busy;
		cause.wbuf_full = exec_req.store && wbuf_full;
		cause.wbuf_drain = exec_req.noncacheable && !wbuf_empty;
		cause.bus_busy = dcache_miss && bus_busy;
		cause.serialize = serialize_req && (nc_busy || !wbuf_empty || refill_active);
		cause.multiple = multiple_active;
		cause.trap_wait = trap_pending;
		cause.iret_wait = iret_pending;
		// A true dependence on the outstanding load stalls, and so does a second load.
		cause.load_use = load_pending && !load_return
			&& (src_a == load_reg || src_b == load_reg
			|| exec_req.load);
		cause.force_hold = ctrl[pipe_hold_pkg::CTRL_FORCE_BIT];
		next_hold = (|cause) && !warn_level;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hold <= 1'b0;
			stage_advance <= 4'h0;
			wbuf_push <= 1'b0;
			nc_start <= 1'b0;
			hold_count <= 32'h0000_0000;
		end else if (ce) begin
			hold <= next_hold;
			stage_advance <= {4{!next_hold}};
			wbuf_push <= exec_req.store && exec_req.cacheable && !next_hold;
			nc_start <= exec_req.noncacheable && !next_hold;
			if (next_hold) begin
				hold_count <= hold_count + 32'h0000_0001;
			end
		end
	end

	branch_sequencer u_branch_sequencer (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.advance(!next_hold),
		.branch_taken(branch_taken),
		.branch_target(branch_target),
		.fetch_pc(fetch_pc),
		.in_delay_slot(in_delay_slot)
	);

	// ================================================================
	// Delayed-effect registers.
	logic [PTR_COUNT-1:0][7:0] ptr_value;
	logic [1:0] freeze_count;
	logic freeze_prev;
	logic cif_write_last;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sp_direct <= 32'h0000_0000;
			sp_local <= 32'h0000_0000;
			ptr_value <= '0;
			ptr_effective <= '0;
			tr_page_size <= pipe_hold_pkg::PAGE_SIZE_RESET;
		end else if (ce) begin
			if (sp_write) begin
				sp_direct <= sp_wdata;
			end
			sp_local <= sp_direct;
			for (int i = 0; i < PTR_COUNT; i++) begin
				if (ptr_write[i]) begin
					ptr_value[i] <= ptr_wdata;
				end
			end
			ptr_effective <= ptr_value;
			tr_page_size <= page_size_field;
		end
	end

	// Interrupts stay disabled until the frozen state has settled.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			freeze_prev <= 1'b0;
			freeze_count <= 2'h0;
			irq_allow <= 1'b0;
		end else if (ce) begin
			freeze_prev <= state_freeze_bit;
			if (freeze_prev && !state_freeze_bit) begin
				freeze_count <= pipe_hold_pkg::FREEZE_SETTLE_CYCLES - 2'h1;
			end else if (freeze_count != 2'h0) begin
				freeze_count <= freeze_count - 2'h1;
			end
			irq_allow <= !state_freeze_bit && !(freeze_prev && !state_freeze_bit)
				&& freeze_count == 2'h0;
		end
	end

	// A fault set in the cycle of its clear survives.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cif_write_last <= 1'b0;
			cache_order_fault <= 1'b0;
			fault <= 1'b0;
		end else if (ce) begin
			cif_write_last <= cache_if_write;
			cache_order_fault <= cif_write_last && cache_data_access;
			if (cif_write_last && cache_data_access) begin
				fault <= 1'b1;
			end else if (fault_clear) begin
				fault <= 1'b0;
			end
		end
	end

	// ================================================================
	// Checks.
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn || !ce);

	sequence s_unfreeze;
		$fell(state_freeze_bit);
	endsequence

	sequence s_order_slip;
		cache_if_write ##1 cache_data_access;
	endsequence

	a_hold_gated_or: assert property (##1 hold == $past(|cause && !warn_level))
		else $error("hold does not follow gated causes");
	a_warn_release: assert property (warn_level |=> !hold && stage_advance == 4'hf)
		else $error("hold held while warning");
	a_trap_hold: assert property (trap_taken ##1 !warn_level |=> hold)
		else $error("trap entry did not hold");
	a_wbuf_stall: assert property (exec_req.store && wbuf_full && !warn_level
		|=> hold && !wbuf_push)
		else $error("store passed a full write buffer");
	a_nc_drain: assert property (exec_req.noncacheable && !wbuf_empty && !warn_level
		|=> hold && !nc_start)
		else $error("noncacheable access before drain");
	a_freeze_settle: assert property (s_unfreeze |-> !irq_allow [*3] ##1 irq_allow
		|| state_freeze_bit)
		else $error("interrupts enabled too early");
	a_sp_lag: assert property (sp_write |=> sp_direct == $past(sp_wdata)
		##1 sp_local == $past(sp_wdata, 2))
		else $error("stack pointer timing wrong");
	a_page_lag: assert property ($changed(page_size_field)
		|=> tr_page_size == $past(page_size_field))
		else $error("page size did not follow");
	a_order_fault: assert property (s_order_slip |=> cache_order_fault && fault)
		else $error("cache order slip not flagged");
	a_bresp_stable: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");

endmodule : pipeline_hold_interlock

// >>> core/pipe_hold_pkg.sv
// ====================================================================
// Shared constants and carriers of the hold and interlock block.
package pipe_hold_pkg;

	// ================================================================
	// Register byte offsets.
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] CONFIG_OFFSET = 8'h04;
	localparam logic [7:0] STATUS_OFFSET = 8'h08;
	localparam logic [7:0] FAULT_OFFSET = 8'h0c;
	localparam logic [7:0] HOLD_COUNT_OFFSET = 8'h10;

	// ================================================================
	// Field positions and reset values.
	localparam int CTRL_FORCE_BIT = 0;
	localparam int CTRL_FREEZE_BIT = 1;
	localparam int PAGE_SIZE_WIDTH = 2;
	localparam int STATUS_HOLD_BIT = 0;
	localparam int STATUS_IRQ_OK_BIT = 1;
	localparam int STATUS_CAUSE_LSB = 16;
	localparam int FAULT_CACHE_ORDER_BIT = 0;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam logic [PAGE_SIZE_WIDTH-1:0] PAGE_SIZE_RESET = 2'h0;
	localparam logic [31:0] RESET_PC = 32'h0000_0000;

	// ================================================================
	// Timing counts in cycles of the 8 ns clock.
	localparam logic [1:0] FREEZE_SETTLE_CYCLES = 2'h2;
	localparam logic [31:0] PC_STEP = 32'h0000_0004;

	// ================================================================
	// AXI responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ================================================================
	// One bit for each reason to hold the pipeline.
	typedef struct packed {
		logic force_hold;
		logic load_use;
		logic iret_wait;
		logic trap_wait;
		logic multiple;
		logic serialize;
		logic bus_busy;
		logic wbuf_drain;
		logic wbuf_full;
		logic nc_conflict;
		logic data_miss;
		logic instr_miss;
	} stall_cause_type;

	// Execute-stage request from the decode and execute logic.
	typedef struct packed {
		logic store;
		logic cacheable;
		logic noncacheable;
		logic load;
		logic [7:0] load_dest;
	} exec_req_type;

endpackage : pipe_hold_pkg

// >>> core/branch_sequencer.sv
`timescale 1ns/1ns
// ====================================================================
// Fetch address sequencing with one delay slot after each branch.
module branch_sequencer (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// Pipeline control.
	input wire logic advance,
	input wire logic branch_taken,
	input wire logic [31:0] branch_target,
	// Fetch side.
	output logic [31:0] fetch_pc,
	output logic in_delay_slot
);
	logic target_pending;
	logic [31:0] target;

	// A taken branch first lets the next sequential word through as its
	// delay slot; a second taken branch there queues its own target.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fetch_pc <= pipe_hold_pkg::RESET_PC;
			target_pending <= 1'b0;
			target <= pipe_hold_pkg::RESET_PC;
			in_delay_slot <= 1'b0;
		end else if (ce && advance) begin
			if (target_pending) begin
				fetch_pc <= target;
			end else begin
				fetch_pc <= fetch_pc + pipe_hold_pkg::PC_STEP;
			end
			target_pending <= branch_taken;
			in_delay_slot <= branch_taken;
			if (branch_taken) begin
				target <= branch_target;
			end
		end
	end

endmodule : branch_sequencer

// >>> bench/mem_side_model.sv
`timescale 1ns/1ns
// ====================================================================
// Caches, write buffer and bus side seen from the hold logic.
module mem_side_model (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Cycles before each answer, so the bench can be prompt or slow.
	input wire logic [3:0] lat,
	// Requests from the block.
	input wire logic instr_needed,
	input wire logic wbuf_push,
	input wire logic nc_start,
	// Answers to the block.
	output logic instr_valid,
	output logic nc_busy,
	output logic wbuf_full,
	output logic wbuf_empty
);
	logic [3:0] icnt;
	logic [3:0] ncnt;
	logic [3:0] dcnt;
	logic [1:0] wcnt;

	// Instruction memory returns the word lat cycles after the request.
	always_ff @(posedge aclk) begin
		if (!aresetn || !instr_needed) begin
			icnt <= 4'h0;
			instr_valid <= 1'b0;
		end else if (icnt >= lat) begin
			instr_valid <= 1'b1;
		end else begin
			icnt <= icnt + 4'h1;
		end
	end

	// A noncacheable access stays outstanding for lat cycles.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nc_busy <= 1'b0;
			ncnt <= 4'h0;
		end else if (nc_start) begin
			nc_busy <= 1'b1;
			ncnt <= lat;
		end else if (ncnt != 4'h0) begin
			ncnt <= ncnt - 4'h1;
		end else begin
			nc_busy <= 1'b0;
		end
	end

	// Two-entry write buffer; memory retires one entry every lat cycles.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wcnt <= 2'h0;
			dcnt <= 4'h0;
		end else if (dcnt >= lat && wcnt != 2'h0 && !wbuf_push) begin
			wcnt <= wcnt - 2'h1;
			dcnt <= 4'h0;
		end else begin
			if (wbuf_push && wcnt != 2'h2) begin
				wcnt <= wcnt + 2'h1;
			end
			dcnt <= (wcnt != 2'h0) ? dcnt + 4'h1 : 4'h0;
		end
	end

	assign wbuf_full = (wcnt == 2'h2);
	assign wbuf_empty = (wcnt == 2'h0);
endmodule : mem_side_model

// >>> bench/pipeline_hold_interlock_tb.sv
`timescale 1ns/1ns
module pipeline_hold_interlock_tb;
	// ================================================================
	// Signals.
	logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, warn_pin = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, src_a = 8'hee, src_b = 8'hee, ptr_wdata = 8'h00;
	logic [31:0] wdata = 32'h0, branch_target = 32'h0, sp_wdata = 32'h0;
	logic [3:0] wstrb = 4'hf, lat = 4'h2;
	logic [2:0] ptr_write = 3'h0;
	logic instr_needed = 1'b0, data_needed = 1'b0, data_valid = 1'b0, dcache_miss = 1'b0;
	logic bus_busy = 1'b0, refill_active = 1'b0, load_return = 1'b0, serialize_req = 1'b0;
	logic multiple_active = 1'b0, trap_taken = 1'b0, iret_exec = 1'b0, handler_in_exec = 1'b0;
	logic iret_done = 1'b0, branch_taken = 1'b0, sp_write = 1'b0;
	logic cache_if_write = 1'b0, cache_data_access = 1'b0;
	pipe_hold_pkg::exec_req_type exec_req = 12'h000;
	logic awready, wready, bvalid, arready, rvalid, instr_valid, nc_busy, wbuf_full, wbuf_empty;
	logic hold, wbuf_push, nc_start, in_delay_slot, irq_allow, cache_order_fault;
	logic [1:0] bresp, rresp, tr_page_size, rs;
	logic [3:0] stage_advance;
	logic [31:0] rdata, fetch_pc, sp_direct, sp_local, rd;
	logic [2:0][7:0] ptr_effective;
	int failures = 0, checked = 0;
	// Hold expected in bit 7, then the seven cause inputs of set_causes.
	localparam logic [7:0] CASES [7] = '{8'hc0, 8'h60, 8'h98, 8'h10, 8'h86, 8'h02, 8'h81};

	pipeline_hold_interlock #(.PTR_COUNT(3)) uut (.*);
	mem_side_model far_side (.*);

	initial begin
		forever #4 aclk = ~aclk;
	end

	// ================================================================
	// Shared tasks.
	task tick(input int k);
		repeat (k) @(posedge aclk);
		#1;
	endtask : tick

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task wrap_up;
		if (failures == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up

	task axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
		#1;
	endtask : axi_wr

	task axi_rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rs = rresp;
		rd = rdata;
		rready <= 1'b0;
		#1;
	endtask : axi_rd

	task set_causes(input logic [6:0] v);
		@(posedge aclk);
		{data_needed, data_valid, dcache_miss, bus_busy, serialize_req, refill_active,
			multiple_active} <= v;
	endtask : set_causes

	task wait_free;
		int n;
		for (n = 0; n < 80 && hold !== 1'b0; n++) begin
			tick(1);
		end
		chk(hold, 1'b0);
	endtask : wait_free

	// ================================================================
	// Scenarios.
	task t_regs;
		axi_rd(pipe_hold_pkg::CTRL_OFFSET);
		chk(rd, 32'h0);
		axi_rd(8'h20);
		chk({rd[29:0], rs}, {30'h0, pipe_hold_pkg::RESP_SLVERR});
		axi_wr(pipe_hold_pkg::STATUS_OFFSET, 32'h1);
		chk(rs, pipe_hold_pkg::RESP_SLVERR);
		axi_wr(pipe_hold_pkg::CONFIG_OFFSET, 32'h3);
		chk(tr_page_size, 2'h3);
		axi_wr(pipe_hold_pkg::CTRL_OFFSET, 32'h2);
		axi_wr(pipe_hold_pkg::CTRL_OFFSET, 32'h0);
		chk(irq_allow, 1'b0);
		tick(1);
		chk(irq_allow, 1'b0);
		tick(1);
		chk(irq_allow, 1'b1);
		axi_wr(pipe_hold_pkg::CTRL_OFFSET, 32'h1);
		tick(1);
		chk(stage_advance, 4'h0);
		axi_rd(pipe_hold_pkg::STATUS_OFFSET);
		chk(rd, 32'h0800_0003);
		axi_wr(pipe_hold_pkg::CTRL_OFFSET, 32'h0);
		wait_free;
	endtask : t_regs

	task t_fault;
		@(posedge aclk);
		cache_if_write <= 1'b1;
		@(posedge aclk);
		cache_if_write <= 1'b0;
		cache_data_access <= 1'b1;
		@(posedge aclk);
		cache_data_access <= 1'b0;
		#1;
		chk(cache_order_fault, 1'b1);
		axi_rd(pipe_hold_pkg::FAULT_OFFSET);
		chk(rd, 32'h1);
		axi_wr(pipe_hold_pkg::FAULT_OFFSET, 32'h1);
		axi_rd(pipe_hold_pkg::FAULT_OFFSET);
		chk(rd, 32'h0);
	endtask : t_fault

	task t_direct;
		int i;
		for (i = 0; i < 7; i++) begin
			set_causes(CASES[i][6:0]);
			tick(1);
			chk(hold, CASES[i][7]);
			chk(stage_advance, {4{~CASES[i][7]}});
			set_causes(7'h00);
			tick(1);
			chk(hold, 1'b0);
		end
	endtask : t_direct

	task t_far;
		@(posedge aclk);
		lat <= 4'h4;
		instr_needed <= 1'b1;
		tick(1);
		chk(hold, 1'b1);
		wait_free;
		@(posedge aclk);
		instr_needed <= 1'b0;
		lat <= 4'hf;
		exec_req <= 12'ha00;
		@(posedge aclk);
		exec_req <= 12'h000;
		#1;
		chk({nc_start, hold}, 2'h2);
		@(posedge aclk);
		exec_req <= 12'ha00;
		tick(2);
		chk(hold, 1'b1);
		@(posedge aclk);
		exec_req <= 12'hc00;
		tick(1);
		chk(wbuf_push, 1'b1);
		tick(3);
		chk(hold, 1'b1);
		@(posedge aclk);
		exec_req <= 12'ha00;
		tick(1);
		chk(hold, 1'b1);
		axi_rd(pipe_hold_pkg::STATUS_OFFSET);
		chk(rd[pipe_hold_pkg::STATUS_CAUSE_LSB + 4], 1'b1);
		@(posedge aclk);
		exec_req <= 12'h000;
		wait_free;
	endtask : t_far

	task t_load;
		@(posedge aclk);
		exec_req <= 12'h505;
		@(posedge aclk);
		exec_req <= 12'h000;
		src_a <= 8'h05;
		tick(1);
		chk(hold, 1'b1);
		@(posedge aclk);
		load_return <= 1'b1;
		@(posedge aclk);
		load_return <= 1'b0;
		tick(1);
		chk(hold, 1'b0);
	endtask : t_load

	task t_trap(input bit ir);
		@(posedge aclk);
		{iret_exec, trap_taken} <= {ir, ~ir};
		@(posedge aclk);
		{iret_exec, trap_taken} <= 2'h0;
		tick(3);
		chk(hold, 1'b1);
		@(posedge aclk);
		{iret_done, handler_in_exec} <= {ir, ~ir};
		@(posedge aclk);
		{iret_done, handler_in_exec} <= 2'h0;
		tick(1);
		chk(hold, 1'b0);
	endtask : t_trap

	task t_warn;
		set_causes(7'h01);
		tick(1);
		chk(hold, 1'b1);
		@(posedge aclk);
		warn_pin <= 1'b1;
		tick(5);
		chk(hold, 1'b0);
		set_causes(7'h00);
		@(posedge aclk);
		warn_pin <= 1'b0;
		tick(5);
	endtask : t_warn

	task t_delays;
		@(posedge aclk);
		sp_write <= 1'b1;
		sp_wdata <= 32'h1234_5678;
		ptr_write <= 3'h2;
		ptr_wdata <= 8'h5a;
		@(posedge aclk);
		sp_write <= 1'b0;
		ptr_write <= 3'h0;
		#1;
		chk(sp_direct, 32'h1234_5678);
		chk(sp_local, 32'h0000_0000);
		chk(ptr_effective[1], 8'h00);
		tick(1);
		chk(sp_local, 32'h1234_5678);
		chk(ptr_effective[1], 8'h5a);
	endtask : t_delays

	task t_ce;
		logic [31:0] pc0;
		@(posedge aclk);
		ce <= 1'b0;
		#1;
		pc0 = fetch_pc;
		tick(3);
		chk(fetch_pc, pc0);
		@(posedge aclk);
		ce <= 1'b1;
		tick(1);
		chk(fetch_pc, pc0 + 32'h0000_0004);
	endtask : t_ce

	task t_branch(input int nb);
		logic [31:0] pc [8];
		logic ds [8];
		int i, k;
		k = 6;
		for (i = 0; i < 8; i++) begin
			@(posedge aclk);
			branch_taken <= (i < nb);
			branch_target <= (i == 0) ? 32'h0000_1000 : 32'h0000_2000;
			#1;
			pc[i] = fetch_pc;
			ds[i] = in_delay_slot;
			if (pc[i] === 32'h0000_1000 && k == 6 && i > 0 && i < 6) k = i;
		end
		if (nb == 2) begin
			chk(pc[k + 1], 32'h0000_2000);
		end else begin
			chk(ds[k - 1], 1'b1);
			chk(pc[k + 1], 32'h0000_1004);
		end
	endtask : t_branch

	// ================================================================
	// Main sequence and watchdog.
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		tick(2);
		chk({hold, stage_advance}, 5'h0f);
		t_regs;
		t_fault;
		t_direct;
		t_far;
		t_load;
		t_trap(1'b0);
		t_trap(1'b1);
		t_warn;
		t_delays;
		t_branch(1);
		t_branch(2);
		t_ce;
		wrap_up;
	end

	initial begin
		#100000;
		failures++;
		wrap_up;
	end
endmodule : pipeline_hold_interlock_tb
